// *** core/tmcs_top.sv ***
// torque command, speed limit select and position/speed mode change logic
// What this block does
// R01 - full-scale analog torque command yields torque set by gain parameter
// R02 - forward alone keeps command sign, reverse alone inverts, else no torque
// R03 - signed offset of up to 999 mV is added to torque command
// R04 - generated torque is always clamped to forward and reverse limits
// R05 - analog torque limit input is ignored in torque control
// R06 - speed limit direction follows rotation selects and analog polarity
// R07 - speed selects pick analog limit or internal limits one to seven
// R08 - speed limiting flag rises when speed reaches the selected limit
// R09 - mode select parameter code enables position/speed change mode
// R10 - change mode is unavailable with absolute position detection
// R11 - change input off selects position, on selects speed control
// R12 - change input switches mode only while zero speed status is active; disabling change mode forces position at once
// R13 - position to speed change clears accumulated droop pulses
// R14 - toggle seen above zero speed is dropped, never applied later
// R15 - after such a toggle, reaching zero speed keeps current mode
// R16 - contact inputs are synchronised before any decode
// R17 - speed limit is an unsigned magnitude, sign from rotation selects and analog polarity
`timescale 1ns/10ps
`default_nettype none
module tmcs_top #(
  parameter int TRQ_W = tmcs_pkg::TRQ_W,
  parameter int SPD_W = tmcs_pkg::SPD_W
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_b_i,
  input  wire tmcs_pkg::tmcs_contact_s       contacts_i,
  input  wire logic signed [TRQ_W-1:0]       analog_torque_command_i,
  input  wire logic signed [TRQ_W-1:0]       analog_torque_limit_in_i,
  input  wire logic signed [SPD_W-1:0]       analog_speed_limit_in_i,
  input  wire logic signed [SPD_W-1:0]       motor_speed_i,
  input  wire logic                          zero_speed_status_i,
  input  wire logic                          abs_position_system_i,
  input  wire logic [TRQ_W-1:0]              torque_cmd_gain_param_i,
  input  wire logic signed [tmcs_pkg::OFFSET_W-1:0] torque_cmd_offset_param_i,
  input  wire logic [TRQ_W-1:0]              forward_torque_limit_param_i,
  input  wire logic [TRQ_W-1:0]              reverse_torque_limit_param_i,
  input  wire logic [tmcs_pkg::INT_LIMITS-1:0][SPD_W-1:0]
                                             internal_speed_limit_i,
  input  wire logic [tmcs_pkg::MODE_PARAM_W-1:0] control_mode_select_param_i,
  output logic signed [TRQ_W:0]              torque_ref_o,
  output logic signed [SPD_W:0]              speed_limit_o,
  output logic                               speed_limiting_flag_o,
  output logic                               change_mode_active_o,
  output tmcs_pkg::tmcs_ctrl_mode_e          ctrl_mode_o,
  output logic                               droop_clear_o
);

  localparam int PW = 2 * TRQ_W + 4;
  localparam logic signed [PW-1:0] FULL_SCALE =
    PW'(tmcs_pkg::TRQ_FULL_SCALE_MV);
  localparam logic signed [tmcs_pkg::OFFSET_W-1:0] OFF_MAX =
    tmcs_pkg::OFFSET_W'(tmcs_pkg::TRQ_OFFSET_MAX_MV);

  if (TRQ_W < 8 || SPD_W < 4)
  begin : g_chk
    $error("tmcs_top: TRQ_W must be >= 8 and SPD_W >= 4");
  end

  tmcs_pkg::tmcs_contact_s sel;
  logic [$bits(tmcs_pkg::tmcs_contact_s)-1:0] sel_vec;

  tmcs_sync #(
    .WIDTH ($bits(tmcs_pkg::tmcs_contact_s))
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (contacts_i),                                  // R16
    .sync_o    (sel_vec)
  );
  assign sel = tmcs_pkg::tmcs_contact_s'(sel_vec);

  logic fwd_only;
  logic rev_only;
  logic [tmcs_pkg::SEL_W-1:0] sel_code;
  assign fwd_only = sel.fwd_rotation_select & ~sel.rev_rotation_select;
  assign rev_only = sel.rev_rotation_select & ~sel.fwd_rotation_select;
  assign sel_code = {sel.speed_select_bit2, sel.speed_select_bit1,
                     sel.speed_select_bit0};

  // torque path; the analog torque limit input is deliberately not read
  logic signed [tmcs_pkg::OFFSET_W-1:0] off_sat;
  logic signed [TRQ_W+1:0]              cmd_sum;
  logic signed [PW-1:0]                 scaled;
  logic signed [PW-1:0]                 directed;
  logic signed [PW-1:0]                 lim_hi;
  logic signed [PW-1:0]                 lim_lo;
  logic signed [TRQ_W:0]                next_torque;

  always_comb
  begin
    if (torque_cmd_offset_param_i > OFF_MAX)                     // R03
      off_sat = OFF_MAX;
    else if (torque_cmd_offset_param_i < -OFF_MAX)
      off_sat = -OFF_MAX;
    else
      off_sat = torque_cmd_offset_param_i;
    cmd_sum = (TRQ_W+2)'(analog_torque_command_i) + (TRQ_W+2)'(off_sat); // R03
    scaled  = (PW'(cmd_sum) * $signed({4'h0, torque_cmd_gain_param_i}))
              / FULL_SCALE;                                      // R01
    if (fwd_only)                                                // R02
      directed = scaled;
    else if (rev_only)
      directed = -scaled;
    else
      directed = '0;
    lim_hi = $signed(PW'(forward_torque_limit_param_i));
    lim_lo = -$signed(PW'(reverse_torque_limit_param_i));
    if (directed > lim_hi)                                       // R04 R05
      next_torque = (TRQ_W+1)'(lim_hi);
    else if (directed < lim_lo)
      next_torque = (TRQ_W+1)'(lim_lo);
    else
      next_torque = (TRQ_W+1)'(directed);
  end

  // speed limit path
  logic [SPD_W-1:0]        spd_mag;
  logic [SPD_W-1:0]        next_spd_mag;
  logic                    dir_ccw;
  logic signed [SPD_W:0]   next_spd_lim;
  logic [SPD_W-1:0]        speed_mag;
  logic                    next_flag;
  logic                    ana_neg;

  always_comb
  begin
    ana_neg = analog_speed_limit_in_i[SPD_W-1];
    if (sel_code == tmcs_pkg::SEL_ANALOG)                        // R07
      next_spd_mag = ana_neg ? SPD_W'(-analog_speed_limit_in_i)
                             : SPD_W'(analog_speed_limit_in_i); // R17
    else
      next_spd_mag = internal_speed_limit_i[sel_code - 3'h1];   // R07
    if (sel_code == tmcs_pkg::SEL_ANALOG)                        // R06
      dir_ccw = fwd_only ? ~ana_neg : ana_neg;
    else
      dir_ccw = fwd_only;
    if (fwd_only || rev_only)
      next_spd_lim = dir_ccw ? $signed({1'b0, next_spd_mag})
                             : -$signed({1'b0, next_spd_mag}); // R17
    else
      next_spd_lim = '0;
    speed_mag = motor_speed_i[SPD_W-1] ? SPD_W'(-motor_speed_i)
                                       : SPD_W'(motor_speed_i);
    next_flag = (speed_mag >= spd_mag);                          // R08
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      torque_ref_o          <= '0;
      spd_mag               <= '0;
      speed_limit_o         <= '0;
      speed_limiting_flag_o <= 1'b0;
    end
    else
    begin
      torque_ref_o          <= next_torque;
      spd_mag               <= next_spd_mag;
      speed_limit_o         <= next_spd_lim;
      speed_limiting_flag_o <= next_flag;
    end
  end

  // mode change: only edges seen while at zero speed take effect
  logic                       chg_prev;
  logic                       chg_edge;
  logic                       enabled;
  logic                       next_chg_prev;
  logic                       next_active;
  logic                       next_droop;
  tmcs_pkg::tmcs_ctrl_mode_e  next_mode;

  always_comb
  begin
    enabled = (control_mode_select_param_i ==
               tmcs_pkg::MODE_POS_SPD_CHANGE)                    // R09
              && !abs_position_system_i;                         // R10
    chg_edge      = sel.control_change_input ^ chg_prev;
    next_chg_prev = sel.control_change_input;
    next_active   = enabled;
    next_mode     = ctrl_mode_o;
    next_droop    = 1'b0;
    if (!enabled)
      next_mode = tmcs_pkg::TMCS_POSITION;
    else if (chg_edge && zero_speed_status_i)                    // R12 R14 R15
    begin
      case (sel.control_change_input)                            // R11
        1'b1:    next_mode = tmcs_pkg::TMCS_SPEED;
        default: next_mode = tmcs_pkg::TMCS_POSITION;
      endcase
      next_droop = (ctrl_mode_o == tmcs_pkg::TMCS_POSITION)
                   && sel.control_change_input;                  // R13
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      chg_prev             <= 1'b0;
      change_mode_active_o <= 1'b0;
      ctrl_mode_o          <= tmcs_pkg::TMCS_POSITION;
      droop_clear_o        <= 1'b0;
    end
    else
    begin
      chg_prev             <= next_chg_prev;
      change_mode_active_o <= next_active;
      ctrl_mode_o          <= next_mode;
      droop_clear_o        <= next_droop;
    end
  end

  no_torque_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (sel.fwd_rotation_select == sel.rev_rotation_select)
    |=> torque_ref_o == '0)                                      // R02
    else $error("torque produced without a single rotation select");

  torque_clamp_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ##1 torque_ref_o <= $signed({1'b0, $past(forward_torque_limit_param_i)})
    && torque_ref_o >= -$signed({1'b0, $past(reverse_torque_limit_param_i)}))
    else $error("torque outside parameter limits");              // R04

  limit_analog_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (sel_code == 3'h0 && !analog_speed_limit_in_i[SPD_W-1])
    |=> spd_mag == $past(analog_speed_limit_in_i))               // R07
    else $error("analog speed limit not selected");

  limit_internal_a: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    (sel_code == 3'h7) |=> spd_mag == $past(internal_speed_limit_i[6]))
    else $error("seventh internal limit not selected");          // R07

  limit_dir_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (rev_only && sel_code != 3'h0 && next_spd_mag != '0)
    |=> speed_limit_o < 0)                                       // R06
    else $error("reverse select with internal limit not CW");

  speed_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ($past(sel_code) == 3'h1 && !motor_speed_i[SPD_W-1]
     && motor_speed_i >= $past(internal_speed_limit_i[0]))
    |=> speed_limiting_flag_o)                                   // R08
    else $error("speed limit reached without flag");

  mode_at_rest_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (change_mode_active_o && $changed(ctrl_mode_o))
    |-> $past(zero_speed_status_i))                              // R12
    else $error("mode changed away from zero speed");

  drop_toggle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (enabled && chg_edge && !zero_speed_status_i)
    ##1 (enabled && sel.control_change_input == chg_prev)[*2]
    |-> $stable(ctrl_mode_o))                                    // R14
    else $error("late toggle applied at zero speed");

  droop_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    droop_clear_o |-> ctrl_mode_o == tmcs_pkg::TMCS_SPEED
    && $past(ctrl_mode_o) == tmcs_pkg::TMCS_POSITION)            // R13
    else $error("droop clear without position to speed change");

  abs_block_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    abs_position_system_i |=> !change_mode_active_o
    && ctrl_mode_o == tmcs_pkg::TMCS_POSITION)                   // R10
    else $error("change mode active with absolute detection");

endmodule
`default_nettype wire

// *** core/tmcs_pkg.sv ***
// shared constants and carriers for the torque and mode command select block
package tmcs_pkg;

  localparam int TRQ_W              = 16;
  localparam int SPD_W              = 16;
  localparam int INT_LIMITS         = 7;
  localparam int SEL_W              = 3;
  localparam int MODE_PARAM_W       = 4;
  localparam int OFFSET_W           = 11;
  localparam int TRQ_FULL_SCALE_MV  = 8000;
  localparam int TRQ_OFFSET_MAX_MV  = 999;
  localparam logic [3:0] MODE_POS_SPD_CHANGE = 4'h1;
  localparam logic [2:0] SEL_ANALOG = 3'h0;

  typedef enum logic [1:0] {
    TMCS_POSITION = 2'b01,
    TMCS_SPEED    = 2'b10
  } tmcs_ctrl_mode_e;

  typedef struct packed {
    logic fwd_rotation_select;
    logic rev_rotation_select;
    logic speed_select_bit2;
    logic speed_select_bit1;
    logic speed_select_bit0;
    logic control_change_input;
  } tmcs_contact_s;

endpackage

// *** core/tmcs_sync.sv ***
// two-flop synchroniser for a vector of independent contact levels
`timescale 1ns/10ps
`default_nettype none
module tmcs_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  if (WIDTH < 1)
  begin : g_chk
    $error("tmcs_sync: WIDTH must be at least 1");
  end

  // each contact is a separate level, so a per-bit flop pair is enough
  always_comb
  begin
    next_meta = async_i;
    next_sync = meta;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end

endmodule
`default_nettype wire

// *** sim/tmcs_ctrl_model.sv ***
// behavioural external controller that drives the contact inputs
`timescale 1ns/10ps
`default_nettype none
module tmcs_ctrl_model (
  input  wire logic          sys_clk_i,
  output tmcs_pkg::tmcs_contact_s contacts_o
);
  initial contacts_o = '0;

  // contacts move just after an edge and then hold as steady levels
  task automatic set_contacts(input tmcs_pkg::tmcs_contact_s c);
    @(posedge sys_clk_i);
    #1;
    contacts_o = c;
  endtask
endmodule
`default_nettype wire

// *** sim/test_torque_mode_command_select.sv ***
// self-checking bench for the torque and mode command select block
`timescale 1ns/10ps
`default_nettype none
module test_torque_mode_command_select;
  logic                  sys_clk_i;
  logic                  rst_b_i;
  tmcs_pkg::tmcs_contact_s contacts;
  logic signed [15:0]    trq_cmd;
  logic signed [15:0]    trq_lim_in;
  logic signed [15:0]    spd_lim_in;
  logic signed [15:0]    motor_speed;
  logic                  zero_speed;
  logic                  abs_sys;
  logic [15:0]           gain;
  logic signed [10:0]    offset;
  logic [15:0]           fwd_lim;
  logic [15:0]           rev_lim;
  logic [6:0][15:0]      int_lim;
  logic [3:0]            mode_param;
  logic signed [16:0]    torque_ref;
  logic signed [16:0]    speed_limit;
  logic                  limiting;
  logic                  change_active;
  tmcs_pkg::tmcs_ctrl_mode_e ctrl_mode;
  logic                  droop_clear;
  int                    miscompares = 0;
  int                    cmp_count = 0;
  int                    droop_n = 0;

  tmcs_ctrl_model u_tmcs_ctrl_model (.sys_clk_i(sys_clk_i),
    .contacts_o(contacts));

  tmcs_top u_tmcs_top (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .contacts_i(contacts),
    .analog_torque_command_i(trq_cmd), .analog_torque_limit_in_i(trq_lim_in),
    .analog_speed_limit_in_i(spd_lim_in), .motor_speed_i(motor_speed),
    .zero_speed_status_i(zero_speed), .abs_position_system_i(abs_sys),
    .torque_cmd_gain_param_i(gain), .torque_cmd_offset_param_i(offset),
    .forward_torque_limit_param_i(fwd_lim),
    .reverse_torque_limit_param_i(rev_lim), .internal_speed_limit_i(int_lim),
    .control_mode_select_param_i(mode_param), .torque_ref_o(torque_ref),
    .speed_limit_o(speed_limit), .speed_limiting_flag_o(limiting),
    .change_mode_active_o(change_active), .ctrl_mode_o(ctrl_mode),
    .droop_clear_o(droop_clear));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
    if (droop_clear === 1'b1) droop_n++;

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic check(input string name, input logic signed [31:0] seen,
                       input logic signed [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  // fwd, rev, speed select code and change input in one contact value
  task automatic drive(input logic f, input logic r, input logic [2:0] s,
                       input logic chg);
    u_tmcs_ctrl_model.set_contacts({f, r, s, chg});
    step(6);
  endtask

  task automatic test_torque();
    // unity gain: torque equals command plus offset in mV
    gain = 16'h1f40;
    offset = 11'sd100;
    fwd_lim = 16'h0bb8;
    rev_lim = 16'h05dc;
    trq_cmd = 16'sd2000;
    trq_lim_in = 16'sd0;
    drive(1'b1, 1'b0, 3'h0, 1'b0);
    check("trq_fwd", torque_ref, 2100);
    drive(1'b0, 1'b1, 3'h0, 1'b0);
    check("trq_rev_clamp", torque_ref, -1500);
    drive(1'b1, 1'b1, 3'h0, 1'b0);
    check("trq_both", torque_ref, 0);
    drive(1'b0, 1'b0, 3'h0, 1'b0);
    check("trq_none", torque_ref, 0);
    trq_cmd = -16'sd2000;
    u_tmcs_ctrl_model.set_contacts({1'b0, 1'b1, 3'h0, 1'b0});
    step(2);
    check("trq_sync", torque_ref, 0);
    step(4);
    check("trq_rev_neg", torque_ref, 1900);
    trq_cmd = 16'sd5000;
    offset = 11'sd999;
    drive(1'b1, 1'b0, 3'h0, 1'b0);
    check("trq_fwd_clamp", torque_ref, 3000);
    gain = 16'h0fa0;
    fwd_lim = 16'h7fff;
    offset = 11'sh3ff;
    step(4);
    check("trq_gain", torque_ref, 2999);
  endtask

  task automatic test_speed();
    int exp;
    spd_lim_in = -16'sd700;
    motor_speed = 16'sd350;
    for (int i = 0; i < 7; i++) int_lim[i] = 16'(100 * (i + 1));
    for (int d = 0; d < 2; d++)
      for (int s = 0; s < 8; s++)
      begin
        drive(d == 0, d == 1, 3'(s), 1'b0);
        exp = (s == 0) ? -700 : 100 * s;
        if (d == 1) exp = -exp;
        check("spd_limit", speed_limit, exp);
        check("spd_flag", limiting, (s > 0 && s < 4));
      end
  endtask

  task automatic test_mode();
    int d0;
    mode_param = 4'h1;
    abs_sys = 1'b0;
    zero_speed = 1'b1;
    drive(1'b0, 1'b0, 3'h0, 1'b0);
    check("mode_active", change_active, 1);
    check("mode_pos", ctrl_mode, tmcs_pkg::TMCS_POSITION);
    d0 = droop_n;
    drive(1'b0, 1'b0, 3'h0, 1'b1);
    check("mode_spd", ctrl_mode, tmcs_pkg::TMCS_SPEED);
    check("droop_once", droop_n - d0, 1);
    zero_speed = 1'b0;
    drive(1'b0, 1'b0, 3'h0, 1'b0);
    check("mode_hold", ctrl_mode, tmcs_pkg::TMCS_SPEED);
    zero_speed = 1'b1;
    step(6);
    check("mode_late", ctrl_mode, tmcs_pkg::TMCS_SPEED);
    drive(1'b0, 1'b0, 3'h0, 1'b1);
    drive(1'b0, 1'b0, 3'h0, 1'b0);
    check("mode_back", ctrl_mode, tmcs_pkg::TMCS_POSITION);
    check("droop_none", droop_n - d0, 1);
    abs_sys = 1'b1;
    drive(1'b0, 1'b0, 3'h0, 1'b1);
    check("abs_off", change_active, 0);
    check("abs_pos", ctrl_mode, tmcs_pkg::TMCS_POSITION);
    abs_sys = 1'b0;
    mode_param = 4'h2;
    step(6);
    check("param_off", change_active, 0);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    rst_b_i = 1'b0;
    trq_cmd = '0;
    trq_lim_in = 16'sh7fff;
    spd_lim_in = '0;
    motor_speed = '0;
    zero_speed = 1'b0;
    abs_sys = 1'b0;
    gain = '0;
    offset = '0;
    fwd_lim = '0;
    rev_lim = '0;
    int_lim = '0;
    mode_param = '0;
    step(20);
    check("rst_mode", ctrl_mode, tmcs_pkg::TMCS_POSITION);
    rst_b_i = 1'b1;
    step(2);
    test_torque();
    test_speed();
    test_mode();
    finish_test();
  end

  initial
  begin
    #20000;
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
